//--- logic/crb_pkg.sv
// Constants of the configuration and status register bank.
// Assumes an 8-bit MPU core with a direct SFR path and an external data path.
// What this block does
// - Unused bits hold nothing, read zero.
// - All bits clear to zero at power-up.
// - Read-only bits ignore processor writes.
// - Frequent bits in SFRs, others at 2xxx.
// - Converter disable bit drives converter off output.
// - Chop codes 00 and 11 enable chopping.
// - Comparator interrupt bits: bit0 comp2, bit1 comp3.
// - Both bits set: interrupt on comp2 XOR comp3.
// - Read-only status shows live comparator outputs.
// - Twelve three-bit fields route pins 0 to 11.
// - Pins sharing a resource combine by fixed rule.
// - Route codes select resources; inputs are ORed.
// - Direction one means output, only for I/O.
// - Display pins read zero; only outputs take writes.
package crb_pkg;
  localparam logic [7:0] SFR_PORT0_PIN_DATA = 8'h80;
  localparam logic [7:0] SFR_PORT1_PIN_DATA = 8'h90;
  localparam logic [7:0] SFR_PORT1_DIRECTION = 8'h91;
  localparam logic [7:0] SFR_FLASH_ERASE_COMMAND = 8'h94;
  localparam logic [7:0] SFR_EEPROM_SERIAL_DATA = 8'h9E;
  localparam logic [7:0] SFR_EEPROM_SERIAL_CONTROL = 8'h9F;
  localparam logic [7:0] SFR_PORT2_PIN_DATA = 8'hA0;
  localparam logic [7:0] SFR_PORT2_DIRECTION = 8'hA1;
  localparam logic [7:0] SFR_PORT0_DIRECTION = 8'hA2;
  localparam logic [7:0] SFR_FLASH_CONTROL = 8'hB2;
  localparam logic [7:0] SFR_FLASH_PAGE_ADDRESS = 8'hB7;
  localparam logic [7:0] SFR_WATCHDOG_AND_CE_IRQ_FLAGS = 8'hE8;
  localparam logic [7:0] SFR_INTERRUPT_INPUT_BITS = 8'hF8;

  localparam logic [15:0] XD_COMPUTE_ENGINE_CONFIG = 16'h2000;
  localparam logic [15:0] XD_COMPUTE_ENGINE_CHOP_CONFIG = 16'h2002;
  localparam logic [15:0] XD_COMPARATOR_CONTROL_STATUS = 16'h2003;
  localparam logic [15:0] XD_ANALOG_CONFIG_A = 16'h2004;
  localparam logic [15:0] XD_ANALOG_CONFIG_B = 16'h2005;
  localparam logic [15:0] XD_PIN_ROUTE_FIRST = 16'h2009;
  localparam logic [15:0] XD_PIN_ROUTE_LAST = 16'h200E;

  localparam int DIO_PINS = 22;
  localparam int ROUTED_PINS = 12;
  localparam int ROUTE_REGS = 6;
  localparam int ROUTE_W = 3;
  localparam int ROUTE_EVEN_LSB = 0;
  localparam int ROUTE_ODD_LSB = 4;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PORT2_MASK = 8'h3F;
  localparam logic [7:0] FLASH_CONTROL_RW_MASK = 8'h03;
  localparam logic [7:0] PAGE_ADDRESS_MASK = 8'h7F;
  localparam logic [7:0] INTERRUPT_INPUT_MASK = 8'h7F;
  localparam logic [7:0] ROUTE_MASK = 8'h77;
  localparam logic [7:0] ANALOG_CONFIG_A_MASK = 8'hBF;
  localparam logic [7:0] COMP_INT_MASK = 8'h18;

  localparam int FLASH_PREBOOT_BIT = 7;
  localparam int FLASH_CODE_PROTECT_LOCK_BIT = 6;
  localparam int WATCHDOG_RESTART_BIT = 7;
  localparam int CE_ZERO_CROSS_BIT = 1;
  localparam int CE_TRANSFER_BIT = 0;
  localparam int CHOP_LSB = 4;
  localparam int COMP_INT_LSB = 3;
  localparam int CONVERTER_DISABLE_BIT = 3;

  localparam logic [2:0] ROUTE_NONE = 3'h0;
  localparam logic [2:0] ROUTE_RESERVED = 3'h1;
  localparam logic [2:0] ROUTE_TIMER0_CLOCK = 3'h2;
  localparam logic [2:0] ROUTE_TIMER1_CLOCK = 3'h3;
  localparam logic [2:0] ROUTE_INT0_RISE = 3'h4;
  localparam logic [2:0] ROUTE_INT1_RISE = 3'h5;
  localparam logic [2:0] ROUTE_INT0_FALL = 3'h6;
  localparam logic [2:0] ROUTE_INT1_FALL = 3'h7;
  localparam int RESOURCES = 8;
endpackage

//--- logic/crb_register_bank.sv
// Configuration and status register bank: SFR slots and 2xxx configuration RAM.
// Assumes one-cycle read and write strobes from the MPU core on ref_clk.
`timescale 1ns/1ns
module crb_register_bank (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic [7:0] xdata_wdata,
  output logic [7:0] xdata_rdata,
  input wire logic [crb_pkg::DIO_PINS-1:0] dio_in,
  output logic [crb_pkg::DIO_PINS-1:0] dio_out,
  output logic [crb_pkg::DIO_PINS-1:0] dio_oe,
  input wire logic [crb_pkg::DIO_PINS-1:0] lcd_pin_select,
  input wire logic [2:0] comparator_out,
  input wire logic [6:0] interrupt_inputs,
  input wire logic preboot_active,
  input wire logic ce_zero_cross_event,
  input wire logic ce_transfer_event,
  output logic comparator_irq,
  output logic timer0_clock_in,
  output logic timer1_clock_in,
  output logic int0_rise_in,
  output logic int1_rise_in,
  output logic int0_fall_in,
  output logic int1_fall_in,
  output logic converter_off,
  output logic bandgap_chop_enable,
  output logic watchdog_restart,
  output logic [7:0] compute_engine_config,
  output logic [7:0] compute_engine_chop_config,
  output logic [7:0] analog_config_a,
  output logic [7:0] analog_config_b,
  output logic [7:0] flash_erase_code,
  output logic [6:0] flash_page_number,
  output logic flash_mpu_erase_enable,
  output logic flash_program_write_enable,
  output logic code_protect_lock,
  output logic [7:0] eeprom_byte,
  output logic [7:0] eeprom_command,
  output logic ce_zero_cross_flag,
  output logic ce_transfer_flag
);
  import crb_pkg::*;

  logic [7:0] port0_dir_bits;
  logic [7:0] port1_dir_bits;
  logic [5:0] port2_dir_bits;
  logic [DIO_PINS-1:0] out_latch;
  logic [1:0] comp_int_sel;
  logic [7:0] pin_route [ROUTE_REGS];
  logic [2:0] comp_prev;
  logic [DIO_PINS-1:0] dir_all;
  logic [DIO_PINS-1:0] gpio_pin;
  logic [DIO_PINS-1:0] pin_read;
  logic [DIO_PINS-1:0] write_mask;
  logic [DIO_PINS-1:0] write_data;
  logic [DIO_PINS-1:0] write_sel;
  logic [RESOURCES-1:0] pin_request [ROUTED_PINS];
  logic [RESOURCES-1:0] next_resource;
  logic next_comp_irq;
  logic [7:0] next_sfr_rdata;
  logic [7:0] next_xdata_rdata;
  logic sfr_wr_wdi;
  logic [15:0] route_index;

  assign dir_all = {port2_dir_bits, port1_dir_bits, port0_dir_bits};
  assign gpio_pin = ~lcd_pin_select;
  // Direction only counts on pins working as general I/O
  assign dio_oe = dir_all & gpio_pin;
  assign dio_out = out_latch;
  // Display pins read back as zero
  assign pin_read = dio_in & gpio_pin;
  assign write_mask = dio_oe;
  assign sfr_wr_wdi = sfr_wr && sfr_addr == SFR_WATCHDOG_AND_CE_IRQ_FLAGS;
  // Offset into the route window, used only inside it
  assign route_index = xdata_addr - XD_PIN_ROUTE_FIRST;

  always_comb begin
    write_sel = '0;
    write_data = '0;
    if (sfr_wr) begin
      case (sfr_addr)
        SFR_PORT0_PIN_DATA: begin
          write_sel[7:0] = 8'hFF;
          write_data[7:0] = sfr_wdata;
        end
        SFR_PORT1_PIN_DATA: begin
          write_sel[15:8] = 8'hFF;
          write_data[15:8] = sfr_wdata;
        end
        SFR_PORT2_PIN_DATA: begin
          write_sel[21:16] = 6'h3F;
          write_data[21:16] = sfr_wdata[5:0];
        end
        default: begin
          write_sel = '0;
        end
      endcase
    end
  end

  // Output latch: only pins driven as outputs accept new data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_latch <= '0;
    end else begin
      out_latch <= (out_latch & ~(write_sel & write_mask)) | (write_data & write_sel & write_mask);
    end
  end

  // Frequently used bits live in the SFR space
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port0_dir_bits <= REG_RESET;
      port1_dir_bits <= REG_RESET;
      port2_dir_bits <= REG_RESET[5:0];
      flash_erase_code <= REG_RESET;
      eeprom_byte <= REG_RESET;
      eeprom_command <= REG_RESET;
      flash_page_number <= REG_RESET[6:0];
      flash_mpu_erase_enable <= 1'b0;
      flash_program_write_enable <= 1'b0;
    end else if (sfr_wr) begin
      case (sfr_addr)
        SFR_PORT0_DIRECTION: port0_dir_bits <= sfr_wdata;
        SFR_PORT1_DIRECTION: port1_dir_bits <= sfr_wdata;
        SFR_PORT2_DIRECTION: port2_dir_bits <= sfr_wdata[5:0];
        SFR_FLASH_ERASE_COMMAND: flash_erase_code <= sfr_wdata;
        SFR_EEPROM_SERIAL_DATA: eeprom_byte <= sfr_wdata;
        SFR_EEPROM_SERIAL_CONTROL: eeprom_command <= sfr_wdata;
        SFR_FLASH_PAGE_ADDRESS: flash_page_number <= sfr_wdata[6:0];
        SFR_FLASH_CONTROL: begin
          flash_mpu_erase_enable <= sfr_wdata[1];
          flash_program_write_enable <= sfr_wdata[0];
        end
        // Unmapped addresses and unused bits are dropped
        default: begin
          flash_erase_code <= flash_erase_code;
        end
      endcase
    end
  end

  // Lock bit accepts ones only; cleared by reset alone
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_protect_lock <= 1'b0;
    end else if (sfr_wr && sfr_addr == SFR_FLASH_CONTROL && sfr_wdata[FLASH_CODE_PROTECT_LOCK_BIT]) begin
      code_protect_lock <= 1'b1;
    end
  end

  // Watchdog restart is a strobe; the stored bit reads back zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= sfr_wr_wdi && sfr_wdata[WATCHDOG_RESTART_BIT];
    end
  end

  // Engine flags: hardware sets, software writes zero to clear, set wins
  // An event in the clearing cycle is kept, never lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ce_zero_cross_flag <= 1'b0;
      ce_transfer_flag <= 1'b0;
    end else begin
      if (ce_zero_cross_event) begin
        ce_zero_cross_flag <= 1'b1;
      end else if (sfr_wr_wdi && !sfr_wdata[CE_ZERO_CROSS_BIT]) begin
        ce_zero_cross_flag <= 1'b0;
      end
      if (ce_transfer_event) begin
        ce_transfer_flag <= 1'b1;
      end else if (sfr_wr_wdi && !sfr_wdata[CE_TRANSFER_BIT]) begin
        ce_transfer_flag <= 1'b0;
      end
    end
  end

  // Remaining configuration bits decode in the 2xxx data space
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compute_engine_config <= REG_RESET;
      compute_engine_chop_config <= REG_RESET;
      analog_config_a <= REG_RESET;
      analog_config_b <= REG_RESET;
      comp_int_sel <= 2'b00;
    end else if (xdata_wr) begin
      case (xdata_addr)
        XD_COMPUTE_ENGINE_CONFIG: compute_engine_config <= xdata_wdata;
        XD_COMPUTE_ENGINE_CHOP_CONFIG: compute_engine_chop_config <= xdata_wdata;
        XD_ANALOG_CONFIG_A: analog_config_a <= xdata_wdata & ANALOG_CONFIG_A_MASK;
        XD_ANALOG_CONFIG_B: analog_config_b <= xdata_wdata;
        // Status bits of this byte are not stored
        XD_COMPARATOR_CONTROL_STATUS: comp_int_sel <= xdata_wdata[COMP_INT_LSB +: 2];
        default: begin
          comp_int_sel <= comp_int_sel;
        end
      endcase
    end
  end

  // Route bytes keep only their two three-bit fields
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < ROUTE_REGS; i++) begin
        pin_route[i] <= REG_RESET;
      end
    end else if (xdata_wr && xdata_addr >= XD_PIN_ROUTE_FIRST && xdata_addr <= XD_PIN_ROUTE_LAST) begin
      pin_route[route_index[2:0]] <= xdata_wdata & ROUTE_MASK;
    end
  end

  assign converter_off = analog_config_b[CONVERTER_DISABLE_BIT];
  assign bandgap_chop_enable = compute_engine_chop_config[CHOP_LSB] ==
    compute_engine_chop_config[CHOP_LSB+1];

  // Comparator change interrupt
  always_comb begin
    next_comp_irq = 1'b0;
    if (comp_int_sel == 2'b11) begin
      next_comp_irq = (comparator_out[1] ^ comparator_out[2]) != (comp_prev[1] ^ comp_prev[2]);
    end else begin
      next_comp_irq = (comp_int_sel[0] && comparator_out[1] != comp_prev[1]) ||
        (comp_int_sel[1] && comparator_out[2] != comp_prev[2]);
    end
  end

  // Follow the pins during reset, so no false change follows it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      comp_prev <= comparator_out;
      comparator_irq <= 1'b0;
    end else begin
      comp_prev <= comparator_out;
      comparator_irq <= next_comp_irq;
    end
  end

  // Pin routing to timer clocks and external interrupts
  genvar p;
  generate
    for (p = 0; p < ROUTED_PINS; p++) begin : g_route
      crb_route_decode u_decode (
        .route(pin_route[p/2][(p%2 == 0 ? ROUTE_EVEN_LSB : ROUTE_ODD_LSB) +: ROUTE_W]),
        .pin(dio_in[p]),
        .request(pin_request[p])
      );
    end
  endgenerate

  always_comb begin
    next_resource = '0;
    for (int i = 0; i < ROUTED_PINS; i++) begin
      next_resource = next_resource | pin_request[i];
    end
  end

  // Levels only; edge detection is left to the timers and interrupts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer0_clock_in <= 1'b0;
      timer1_clock_in <= 1'b0;
      int0_rise_in <= 1'b0;
      int1_rise_in <= 1'b0;
      int0_fall_in <= 1'b0;
      int1_fall_in <= 1'b0;
    end else begin
      timer0_clock_in <= next_resource[ROUTE_TIMER0_CLOCK];
      timer1_clock_in <= next_resource[ROUTE_TIMER1_CLOCK];
      int0_rise_in <= next_resource[ROUTE_INT0_RISE];
      int1_rise_in <= next_resource[ROUTE_INT1_RISE];
      int0_fall_in <= next_resource[ROUTE_INT0_FALL];
      int1_fall_in <= next_resource[ROUTE_INT1_FALL];
    end
  end

  // SFR read mux; unused bits and unmapped addresses read zero
  always_comb begin
    next_sfr_rdata = 8'h00;
    case (sfr_addr)
      SFR_PORT0_PIN_DATA: next_sfr_rdata = pin_read[7:0];
      SFR_PORT1_PIN_DATA: next_sfr_rdata = pin_read[15:8];
      SFR_PORT2_PIN_DATA: next_sfr_rdata = {2'b00, pin_read[21:16]};
      SFR_PORT0_DIRECTION: next_sfr_rdata = port0_dir_bits;
      SFR_PORT1_DIRECTION: next_sfr_rdata = port1_dir_bits;
      SFR_PORT2_DIRECTION: next_sfr_rdata = {2'b00, port2_dir_bits};
      SFR_FLASH_ERASE_COMMAND: next_sfr_rdata = flash_erase_code;
      SFR_EEPROM_SERIAL_DATA: next_sfr_rdata = eeprom_byte;
      SFR_EEPROM_SERIAL_CONTROL: next_sfr_rdata = eeprom_command;
      SFR_FLASH_PAGE_ADDRESS: next_sfr_rdata = {1'b0, flash_page_number};
      SFR_FLASH_CONTROL: next_sfr_rdata = {preboot_active, code_protect_lock, 4'h0,
        flash_mpu_erase_enable, flash_program_write_enable};
      SFR_WATCHDOG_AND_CE_IRQ_FLAGS: next_sfr_rdata = {6'h00, ce_zero_cross_flag, ce_transfer_flag};
      SFR_INTERRUPT_INPUT_BITS: next_sfr_rdata = {1'b0, interrupt_inputs} & INTERRUPT_INPUT_MASK;
      default: next_sfr_rdata = 8'h00;
    endcase
  end

  // Configuration RAM read mux
  always_comb begin
    next_xdata_rdata = 8'h00;
    case (xdata_addr)
      XD_COMPUTE_ENGINE_CONFIG: next_xdata_rdata = compute_engine_config;
      XD_COMPUTE_ENGINE_CHOP_CONFIG: next_xdata_rdata = compute_engine_chop_config;
      XD_COMPARATOR_CONTROL_STATUS: next_xdata_rdata = {3'b000, comp_int_sel, comparator_out};
      XD_ANALOG_CONFIG_A: next_xdata_rdata = analog_config_a;
      XD_ANALOG_CONFIG_B: next_xdata_rdata = analog_config_b;
      // Route window; every other byte reads zero
      default: begin
        if (xdata_addr >= XD_PIN_ROUTE_FIRST && xdata_addr <= XD_PIN_ROUTE_LAST) begin
          next_xdata_rdata = pin_route[route_index[2:0]];
        end else begin
          next_xdata_rdata = 8'h00;
        end
      end
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      xdata_rdata <= 8'h00;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= next_sfr_rdata;
      end
      if (xdata_rd) begin
        xdata_rdata <= next_xdata_rdata;
      end
    end
  end
endmodule

//--- logic/crb_route_decode.sv
// Decodes one pin's routing field into a one-hot resource request.
// Assumes the pin level is already synchronous to the MPU clock.
`timescale 1ns/1ns
module crb_route_decode (
  input wire logic [crb_pkg::ROUTE_W-1:0] route,
  input wire logic pin,
  output logic [crb_pkg::RESOURCES-1:0] request
);
  import crb_pkg::*;

  always_comb begin
    request = '0;
    // Code zero and the reserved code drive nothing
    if (route != ROUTE_NONE && route != ROUTE_RESERVED) begin
      request[route] = pin;
    end
  end
endmodule

//--- sim/crb_mpu_model.sv
// MPU core model: drives the SFR and configuration RAM strobes.
// Assumes the bank takes a request on the rising ref_clk edge, no wait states.
`timescale 1ns/1ns
module crb_mpu_model (
  input wire logic ref_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic [15:0] xdata_addr,
  output logic xdata_wr,
  output logic xdata_rd,
  output logic [7:0] xdata_wdata,
  input wire logic [7:0] xdata_rdata
);
  initial begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = 18'h0;
    {xdata_addr, xdata_wr, xdata_rd, xdata_wdata} = 26'h0;
  end
  // Direct SFR access, one-cycle strobe
  task automatic sfr_access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
    #1;
    q = sfr_rdata;
  endtask
  // External data space access at 2xxx
  task automatic xd_access(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    xdata_addr <= a;
    xdata_wdata <= d;
    xdata_wr <= w;
    xdata_rd <= !w;
    @(posedge ref_clk);
    xdata_wr <= 1'b0;
    xdata_rd <= 1'b0;
    xdata_addr <= ~a;
    xdata_wdata <= ~d;
    #1;
    q = xdata_rdata;
  endtask
endmodule

//--- sim/crb_register_bank_assertions.sv
// Checker: timing relations at the register bank ports.
// Assumes it is bound into crb_register_bank.
`timescale 1ns/1ns
module crb_register_bank_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic [7:0] xdata_wdata,
  input wire logic [7:0] xdata_rdata,
  input wire logic [crb_pkg::DIO_PINS-1:0] dio_oe,
  input wire logic [crb_pkg::DIO_PINS-1:0] lcd_pin_select,
  input wire logic [2:0] comparator_out,
  input wire logic [6:0] interrupt_inputs,
  input wire logic comparator_irq,
  input wire logic converter_off,
  input wire logic [7:0] analog_config_b,
  input wire logic [7:0] compute_engine_chop_config,
  input wire logic bandgap_chop_enable,
  input wire logic watchdog_restart
);
  import crb_pkg::*;
  logic [1:0] sel_q;
  // Shadow of the comparator interrupt selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_q <= 2'h0;
    end else if (xdata_wr && xdata_addr == XD_COMPARATOR_CONTROL_STATUS) begin
      sel_q <= xdata_wdata[4:3];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_conv_off: assert property (converter_off == analog_config_b[CONVERTER_DISABLE_BIT])
    else $error("converter control mismatch");
  a_chop_map: assert property (bandgap_chop_enable ==
    (compute_engine_chop_config[5] == compute_engine_chop_config[4]))
    else $error("chop enable mismatch");
  a_irq_comp2: assert property (sel_q == 2'h1 && $changed(comparator_out[1]) |=> comparator_irq)
    else $error("missing comparator interrupt");
  a_irq_xor: assert property (sel_q == 2'h3 && $changed(^comparator_out[2:1]) |=> comparator_irq)
    else $error("missing xor interrupt");
  a_irq_quiet: assert property (sel_q == 2'h0 |=> !comparator_irq)
    else $error("interrupt while deselected");
  a_wd_pulse: assert property (sfr_wr && sfr_addr == SFR_WATCHDOG_AND_CE_IRQ_FLAGS && sfr_wdata[7]
    |=> watchdog_restart ##1 (!watchdog_restart ||
    $past(sfr_wr && sfr_addr == SFR_WATCHDOG_AND_CE_IRQ_FLAGS && sfr_wdata[7])))
    else $error("watchdog restart pulse wrong");
  a_oe_lcd: assert property ((dio_oe & lcd_pin_select) == '0)
    else $error("display pin enabled as output");
  a_stat_read: assert property (xdata_rd && xdata_addr == XD_COMPARATOR_CONTROL_STATUS
    |=> xdata_rdata[2:0] == $past(comparator_out) && xdata_rdata[7:5] == 3'h0)
    else $error("comparator status readback wrong");
  a_int_read: assert property (sfr_rd && sfr_addr == SFR_INTERRUPT_INPUT_BITS
    |=> sfr_rdata == {1'b0, $past(interrupt_inputs)})
    else $error("interrupt input readback wrong");
endmodule
bind crb_register_bank crb_register_bank_assertions i_chk (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .xdata_addr, .xdata_wr, .xdata_rd, .xdata_wdata, .xdata_rdata, .dio_oe, .lcd_pin_select,
  .comparator_out, .interrupt_inputs, .comparator_irq, .converter_off, .analog_config_b,
  .compute_engine_chop_config, .bandgap_chop_enable, .watchdog_restart);

//--- sim/crb_register_bank_tb.sv
// Testbench of the configuration register bank, driven through the MPU model.
// Assumes crb_pkg, the design, the model and the checker are compiled first.
`timescale 1ns/1ns
module crb_register_bank_tb;
  import crb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, xdata_rdata, q;
  logic [15:0] xdata_addr;
  logic sfr_wr, sfr_rd, xdata_wr, xdata_rd;
  logic [21:0] dio_in = '0, lcd_pin_select = '0, dio_out, dio_oe;
  logic [2:0] comparator_out = '0;
  logic [6:0] interrupt_inputs = '0, flash_page_number;
  logic preboot_active = 1'b0, ce_zero_cross_event = 1'b0, ce_transfer_event = 1'b0;
  logic comparator_irq, timer0_clock_in, timer1_clock_in, int0_rise_in, int1_rise_in, int0_fall_in, int1_fall_in;
  logic converter_off, bandgap_chop_enable, watchdog_restart, code_protect_lock;
  logic [7:0] compute_engine_config, analog_config_a, flash_erase_code, eeprom_byte, eeprom_command;
  logic ce_zero_cross_flag, ce_transfer_flag, flash_mpu_erase_enable, flash_program_write_enable;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 ref_clk = ~ref_clk;
  crb_mpu_model i_mpu (.ref_clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .xdata_addr, .xdata_wr,
    .xdata_rd, .xdata_wdata, .xdata_rdata);
  crb_register_bank i_dut (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .xdata_addr,
    .xdata_wr, .xdata_rd, .xdata_wdata, .xdata_rdata, .dio_in, .dio_out, .dio_oe, .lcd_pin_select, .comparator_out,
    .interrupt_inputs, .preboot_active, .ce_zero_cross_event, .ce_transfer_event, .comparator_irq, .timer0_clock_in,
    .timer1_clock_in, .int0_rise_in, .int1_rise_in, .int0_fall_in, .int1_fall_in, .converter_off,
    .bandgap_chop_enable, .watchdog_restart, .compute_engine_config, .compute_engine_chop_config(),
    .analog_config_a, .analog_config_b(), .flash_erase_code, .flash_page_number, .flash_mpu_erase_enable,
    .flash_program_write_enable, .code_protect_lock, .eeprom_byte, .eeprom_command, .ce_zero_cross_flag,
    .ce_transfer_flag);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    i_mpu.sfr_access(a, 1'b1, d, q);
  endtask
  task automatic sr(input logic [7:0] a);
    i_mpu.sfr_access(a, 1'b0, 8'h00, q);
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    i_mpu.xd_access(a, 1'b1, d, q);
  endtask
  task automatic xr(input logic [15:0] a);
    i_mpu.xd_access(a, 1'b0, 8'h00, q);
  endtask
  task automatic t_reset;
    logic [7:0] sl [6] = '{8'h91, 8'h94, 8'h9F, 8'hB2, 8'hB7, 8'hE8};
    foreach (sl[i]) begin
      sr(sl[i]);
      check("sfr reset", q, 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      xr(16'h2000 + 16'(i));
      check("xdata reset", q, 8'h00);
    end
    $display("t_reset done");
  endtask
  task automatic t_masks;
    logic [7:0] sa [9] = '{8'h91, 8'h94, 8'h9E, 8'h9F, 8'hA1, 8'hB7, 8'h55, 8'hB2, 8'hB2};
    logic [7:0] se [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7F, 8'h00, 8'hC3, 8'hC0};
    logic [15:0] xa [5] = '{16'h2000, 16'h2004, 16'h2009, 16'h200E, 16'h2006};
    logic [7:0] xd [5] = '{8'hFF, 8'hCF, 8'hFF, 8'hFF, 8'hFF}; // 2004 reserved bit 6 written as one, reads back zero
    logic [7:0] xe [5] = '{8'hFF, 8'h8F, 8'h77, 8'h77, 8'h00};
    @(posedge ref_clk);
    preboot_active <= 1'b1;
    foreach (sa[i]) begin
      sw(sa[i], (i == 8) ? 8'h00 : 8'hFF);
      sr(sa[i]);
      check("sfr mask", q, se[i]);
    end
    check("lock", code_protect_lock, 1'b1);
    check("page", flash_page_number, 7'h7F);
    check("sfr outs", {flash_erase_code, eeprom_byte, eeprom_command}, 24'hFFFFFF);
    sw(8'hB2, 8'h03);
    check("flash en", {flash_mpu_erase_enable, flash_program_write_enable}, 2'h3);
    foreach (xa[i]) begin
      xw(xa[i], xd[i]);
      xr(xa[i]);
      check("xdata mask", q, xe[i]);
    end
    check("xd outs", {compute_engine_config, analog_config_a}, 16'hFF8F);
    $display("t_masks done");
  endtask
  task automatic t_status;
    @(posedge ref_clk);
    interrupt_inputs <= 7'h55;
    comparator_out <= 3'b101;
    sw(8'hF8, 8'hFF);
    sr(8'hF8);
    check("int bits", q, 8'h55);
    xw(16'h2003, 8'hFF);
    xr(16'h2003);
    check("comp status", q, 8'h1D);
    @(posedge ref_clk);
    ce_zero_cross_event <= 1'b1;
    ce_transfer_event <= 1'b1;
    @(posedge ref_clk);
    ce_zero_cross_event <= 1'b0;
    ce_transfer_event <= 1'b0;
    sw(8'hE8, 8'h82);
    sr(8'hE8);
    check("event flags", q, 8'h02);
    check("flag outs", {ce_zero_cross_flag, ce_transfer_flag}, 2'h2);
    $display("t_status done");
  endtask
  task automatic t_analog;
    xw(16'h2005, 8'h08);
    check("conv off", converter_off, 1'b1);
    xw(16'h2005, 8'h00);
    check("conv on", converter_off, 1'b0);
    for (int c = 0; c < 4; c++) begin
      xw(16'h2002, 8'(c << 4));
      check("chop", bandgap_chop_enable, (c == 0 || c == 3));
    end
    $display("t_analog done");
  endtask
  task automatic pulse_comp(input logic [2:0] m, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk);
    comparator_out <= comparator_out ^ m;
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      seen = seen | comparator_irq;
    end
    check("comp irq", seen, e);
  endtask
  task automatic t_comp;
    for (int s = 0; s < 4; s++) begin
      xw(16'h2003, 8'(s << 3));
      pulse_comp(3'b010, s[0]);
      pulse_comp(3'b100, s[1]);
      pulse_comp(3'b001, 1'b0);
    end
    pulse_comp(3'b110, 1'b0);
    xw(16'h2003, 8'h00);
    $display("t_comp done");
  endtask
  task automatic t_route;
    xw(16'h200E, 8'h00);
    @(posedge ref_clk);
    dio_in <= 22'h000802;
    for (int c = 1; c < 8; c++) begin
      xw(16'h2009, 8'(c * 17));
      @(posedge ref_clk);
      #1;
      check("route", {int1_fall_in, int0_fall_in, int1_rise_in, int0_rise_in, timer1_clock_in, timer0_clock_in},
        (c < 2) ? 0 : (1 << (c - 2)));
    end
    xw(16'h2009, 8'h00);
    xw(16'h200E, 8'h40);
    @(posedge ref_clk);
    #1;
    check("route pin11", {int1_fall_in, int0_fall_in, int1_rise_in, int0_rise_in, timer1_clock_in, timer0_clock_in},
      6'h04);
    $display("t_route done");
  endtask
  task automatic t_ports;
    @(posedge ref_clk);
    lcd_pin_select <= 22'h000002;
    dio_in <= 22'h0000FF;
    sw(8'hA2, 8'h0F);
    check("dir oe", dio_oe[7:0], 8'h0D);
    sw(8'h80, 8'hFF);
    check("port latch", dio_out[7:0], 8'h0D);
    sr(8'h80);
    check("port read", q, 8'hFD);
    sw(8'hA0, 8'hFF);
    sw(8'h90, 8'h5A);
    check("port hi latch", dio_out[21:8], 14'h3F5A);
    $display("t_ports done");
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_status();
    t_analog();
    t_comp();
    t_route();
    t_ports();
    give_verdict();
  end
endmodule
